// file: verilog/pfcb_top.sv
// Pin function configuration bank with Avalon-MM register slave
`timescale 1ns/10ps
module pfcb_top
    import pfcb_pkg::*;
(
    input  wire logic                       clk,                 // 125 MHz clock
    input  wire logic                       rst,                 // Async reset, active high
    input  wire logic [pfcb_pkg::ADDR_W-1:0] avs_address,        // Byte address
    input  wire logic                       avs_read,            // Read request
    input  wire logic                       avs_write,           // Write request
    input  wire logic [pfcb_pkg::DATA_W-1:0] avs_writedata,      // Write data
    input  wire logic [3:0]                 avs_byteenable,      // Byte enables
    output logic      [pfcb_pkg::DATA_W-1:0] avs_readdata,       // Read data
    output logic                            avs_waitrequest,     // Stall
    output logic                            alert_out,           // Alert interrupt drive
    output logic                            alert_oe,            // Alert pin driven
    output logic                            meas_2v5_en,         // 2.5 V input measured
    output logic                            thermal_event_line_en, // 5 V pin is thermal line
    output logic                            meas_5v_en,          // 5 V input measured
    output logic                            thermal_monitor_active, // Thermal monitoring on
    output logic [7:0]                      tach_threshold_mv,   // Fan input threshold, mV
    output logic [1:0]                      tach_threshold_select // Threshold code
);
    import pfcb_pkg::*;

    // Register bank state
    logic [7:0]  pin_cfg_r;
    logic [7:0]  pin_cfg_nxt;
    logic [7:0]  ctrl_r;
    logic [7:0]  ctrl_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        ack_r;
    logic        ack_nxt;
    logic        wait_r;
    logic        wait_nxt;

    // Pin function state
    logic        alert_out_r;
    logic        alert_out_nxt;
    logic        alert_oe_r;
    logic        alert_oe_nxt;
    logic        m25_r;
    logic        m25_nxt;
    logic        tline_r;
    logic        tline_nxt;
    logic        m5_r;
    logic        m5_nxt;
    logic        tmon_r;
    logic        tmon_nxt;
    logic [7:0]  thr_r;
    logic [7:0]  thr_nxt;
    logic [1:0]  thsel_r;
    logic [1:0]  thsel_nxt;

    // Bus decode
    logic        alert_cond;
    logic        req;
    logic        wr_go;
    logic        rd_go;
    logic        hit_pin_cfg;
    logic        hit_ctrl;
    logic        cfg_locked;

    function automatic logic [7:0] thr_decode(input logic [1:0] code);
        case (code)
            2'h0:    thr_decode = THR_MV_CODE0;
            2'h1:    thr_decode = THR_MV_CODE1;
            2'h2:    thr_decode = THR_MV_CODE2;
            default: thr_decode = THR_MV_CODE3;
        endcase
    endfunction

    // Out-of-limit condition is tied low; no monitoring logic or input drives it in this bank
    assign alert_cond = 1'b0;

    assign req         = (avs_read | avs_write) & ~ack_r;
    assign wr_go       = avs_write & ~ack_r & avs_byteenable[0];
    assign rd_go       = avs_read & ~ack_r;
    assign hit_pin_cfg = (avs_address == OFF_PIN_CFG);
    assign hit_ctrl    = (avs_address == OFF_CTRL);
    assign cfg_locked  = ctrl_r[BIT_LOCK];

    // One wait cycle: request taken, answer given on next edge
    always_comb begin
        pin_cfg_nxt = pin_cfg_r;
        ctrl_nxt    = ctrl_r;
        rdata_nxt   = rdata_r;
        ack_nxt     = req;
        wait_nxt    = ~req;
        if (wr_go && avs_address == OFF_PIN_CFG && !ctrl_r[BIT_LOCK]) begin
            pin_cfg_nxt = avs_writedata[7:0] & PIN_CFG_MASK;
        end
        if (wr_go && avs_address == OFF_CTRL) begin
            ctrl_nxt = (avs_writedata[7:0] & CTRL_MASK) | {7'h00, ctrl_r[BIT_LOCK]};
        end
        if (avs_read && !ack_r) begin
            case (avs_address)
                OFF_PIN_CFG:  rdata_nxt = {24'h000000, pin_cfg_r};
                OFF_TEST_ONE: rdata_nxt = {24'h000000, TEST_RST};
                OFF_TEST_TWO: rdata_nxt = {24'h000000, TEST_RST};
                OFF_CTRL:     rdata_nxt = {24'h000000, ctrl_r};
                default:      rdata_nxt = UNMAPPED_DATA;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_cfg_r <= PIN_CFG_RST;
            ctrl_r    <= CTRL_RST;
            rdata_r   <= 32'h0000_0000;
            ack_r     <= 1'b0;
            wait_r    <= 1'b1;
        end else begin
            pin_cfg_r <= pin_cfg_nxt;
            ctrl_r    <= ctrl_nxt;
            rdata_r   <= rdata_nxt;
            ack_r     <= ack_nxt;
            wait_r    <= wait_nxt;
        end
    end

    // Pin function outputs follow the configuration one cycle later
    always_comb begin
        alert_oe_nxt  = pin_cfg_r[BIT_ALERT_SEL];
        alert_out_nxt = pin_cfg_r[BIT_ALERT_SEL] & alert_cond;
        m25_nxt       = ~pin_cfg_r[BIT_ALERT_SEL];
        tline_nxt     = pin_cfg_r[BIT_THERMAL_EVENT_LINE_SEL];
        m5_nxt        = ~pin_cfg_r[BIT_THERMAL_EVENT_LINE_SEL];
        tmon_nxt      = pin_cfg_r[BIT_THERMAL_EVENT_LINE_SEL] & ctrl_r[BIT_THERMAL_EVENT_LINE_EN];
        thr_nxt       = thr_decode(pin_cfg_r[BIT_THR_HI:BIT_THR_LO]);
        thsel_nxt     = pin_cfg_r[BIT_THR_HI:BIT_THR_LO];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alert_out_r <= 1'b0;
            alert_oe_r  <= 1'b0;
            m25_r       <= 1'b1;
            tline_r     <= 1'b0;
            m5_r        <= 1'b1;
            tmon_r      <= 1'b0;
            thr_r       <= THR_MV_CODE0;
            thsel_r     <= 2'h0;
        end else begin
            alert_out_r <= alert_out_nxt;
            alert_oe_r  <= alert_oe_nxt;
            m25_r       <= m25_nxt;
            tline_r     <= tline_nxt;
            m5_r        <= m5_nxt;
            tmon_r      <= tmon_nxt;
            thr_r       <= thr_nxt;
            thsel_r     <= thsel_nxt;
        end
    end

    assign avs_readdata           = rdata_r;
    assign avs_waitrequest        = wait_r;
    assign alert_out              = alert_out_r;
    assign alert_oe               = alert_oe_r;
    assign meas_2v5_en            = m25_r;
    assign thermal_event_line_en  = tline_r;
    assign meas_5v_en             = m5_r;
    assign thermal_monitor_active = tmon_r;
    assign tach_threshold_mv      = thr_r;
    assign tach_threshold_select  = thsel_r;

    // Bus handshake
    a_take_answer: assert property (@(posedge clk) disable iff (rst)
        req |=> !avs_waitrequest)
        else $error("no answer after request");

    a_answer_once: assert property (@(posedge clk) disable iff (rst)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("answer held too long");

    a_wait_idle: assert property (@(posedge clk) disable iff (rst)
        !avs_read && !avs_write |=> avs_waitrequest)
        else $error("answer without request");

    a_ack_match: assert property (@(posedge clk) disable iff (rst)
        ack_r == !avs_waitrequest)
        else $error("stall and answer disagree");

    a_read_cfg: assert property (@(posedge clk) disable iff (rst)
        rd_go && hit_pin_cfg |=> avs_readdata == {24'h000000, $past(pin_cfg_r)})
        else $error("config readback wrong");

    a_read_ctrl: assert property (@(posedge clk) disable iff (rst)
        rd_go && hit_ctrl |=> avs_readdata == {24'h000000, $past(ctrl_r)})
        else $error("control readback wrong");

    a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
        rd_go && avs_address < OFF_PIN_CFG |=> avs_readdata == UNMAPPED_DATA)
        else $error("unmapped read nonzero");

    a_read_keep: assert property (@(posedge clk) disable iff (rst)
        !rd_go |=> $stable(avs_readdata))
        else $error("read data changed without read");

    // Configuration and control registers
    a_lock_holds: assert property (@(posedge clk) disable iff (rst)
        ctrl_r[BIT_LOCK] |=> $stable(pin_cfg_r))
        else $error("locked register changed");

    a_lock_sticky: assert property (@(posedge clk) disable iff (rst)
        ctrl_r[BIT_LOCK] |=> ctrl_r[BIT_LOCK])
        else $error("lock cleared");

    a_locked_write: assert property (@(posedge clk) disable iff (rst)
        wr_go && hit_pin_cfg && cfg_locked |=> $stable(pin_cfg_r))
        else $error("locked write landed");

    a_write_lands: assert property (@(posedge clk) disable iff (rst)
        wr_go && hit_pin_cfg && !cfg_locked |=> pin_cfg_r == ($past(avs_writedata[7:0]) & PIN_CFG_MASK))
        else $error("config write lost");

    a_cfg_quiet: assert property (@(posedge clk) disable iff (rst)
        !(wr_go && hit_pin_cfg) |=> $stable(pin_cfg_r))
        else $error("config changed without write");

    a_upper_zero: assert property (@(posedge clk) disable iff (rst)
        pin_cfg_r[7:4] == 4'h0)
        else $error("upper bits not zero");

    a_ctrl_upper: assert property (@(posedge clk) disable iff (rst)
        ctrl_r[7:2] == 6'h00)
        else $error("control upper bits set");

    a_test_zero: assert property (@(posedge clk) disable iff (rst)
        rd_go && avs_address == OFF_TEST_ONE |=> avs_readdata == 32'h0000_0000)
        else $error("test reg one nonzero");

    a_test_two: assert property (@(posedge clk) disable iff (rst)
        rd_go && avs_address == OFF_TEST_TWO |=> avs_readdata == 32'h0000_0000)
        else $error("test reg two nonzero");

    // Pin routing
    a_alert_route: assert property (@(posedge clk) disable iff (rst)
        alert_oe == ~meas_2v5_en)
        else $error("alert pin both roles");

    a_alert_enable: assert property (@(posedge clk) disable iff (rst)
        pin_cfg_r[BIT_ALERT_SEL] |=> alert_oe && !meas_2v5_en)
        else $error("alert output not driven");

    a_alert_quiet: assert property (@(posedge clk) disable iff (rst)
        !pin_cfg_r[BIT_ALERT_SEL] |=> !alert_out)
        else $error("alert driven as input");

    a_meas_2v5: assert property (@(posedge clk) disable iff (rst)
        !pin_cfg_r[BIT_ALERT_SEL] |=> meas_2v5_en && !alert_oe)
        else $error("2.5 V input lost");

    a_thermal_line: assert property (@(posedge clk) disable iff (rst)
        pin_cfg_r[BIT_THERMAL_EVENT_LINE_SEL] |=> thermal_event_line_en && !meas_5v_en)
        else $error("thermal line off");

    a_thermal_event_line_route: assert property (@(posedge clk) disable iff (rst)
        thermal_event_line_en == ~meas_5v_en)
        else $error("5 V pin both roles");

    a_meas_5v: assert property (@(posedge clk) disable iff (rst)
        !pin_cfg_r[BIT_THERMAL_EVENT_LINE_SEL] |=> meas_5v_en)
        else $error("5 V input lost");

    // Fan input threshold
    a_thr_min: assert property (@(posedge clk) disable iff (rst)
        pin_cfg_r[3:2] == 2'h0 |=> tach_threshold_mv == 8'h14)
        else $error("threshold code 0 wrong");

    a_thr_code1: assert property (@(posedge clk) disable iff (rst)
        pin_cfg_r[3:2] == 2'h1 |=> tach_threshold_mv == 8'h28)
        else $error("threshold code 1 wrong");

    a_thr_code2: assert property (@(posedge clk) disable iff (rst)
        pin_cfg_r[3:2] == 2'h2 |=> tach_threshold_mv == 8'h50)
        else $error("threshold code 2 wrong");

    a_thr_max: assert property (@(posedge clk) disable iff (rst)
        pin_cfg_r[3:2] == 2'h3 |=> tach_threshold_mv == 8'h82)
        else $error("threshold code 3 wrong");

    a_thr_select: assert property (@(posedge clk) disable iff (rst)
        tach_threshold_select == $past(pin_cfg_r[3:2]))
        else $error("threshold code not passed");

    // Thermal monitoring
    a_mon_enable: assert property (@(posedge clk) disable iff (rst)
        thermal_monitor_active |-> $past(ctrl_r[BIT_THERMAL_EVENT_LINE_EN]))
        else $error("monitor without enable");

    a_mon_pin: assert property (@(posedge clk) disable iff (rst)
        thermal_monitor_active |-> thermal_event_line_en)
        else $error("monitor without thermal pin");

    a_mon_on: assert property (@(posedge clk) disable iff (rst)
        pin_cfg_r[BIT_THERMAL_EVENT_LINE_SEL] && ctrl_r[BIT_THERMAL_EVENT_LINE_EN] |=> thermal_monitor_active)
        else $error("monitor not started");

    a_mon_off: assert property (@(posedge clk) disable iff (rst)
        !ctrl_r[BIT_THERMAL_EVENT_LINE_EN] |=> !thermal_monitor_active)
        else $error("monitor on while disabled");

endmodule // pfcb_top

// file: shared/pfcb_pkg.sv
// Constants for the pin function configuration bank
// Function
// - Alert select 1 makes the shared analog pin an alert interrupt output.
// - Alert select 0 makes that pin a 2.5 V measurement input.
// - Thermal select 1 makes the 5 V pin the thermal event line.
// - Thermal select 0 makes that pin a 5 V measurement input.
// - Threshold code 00..11 selects 20, 40, 80, 130 mV fan input threshold.
// - With global lock set, the configuration register ignores all writes.
// - Thermal monitor enable activates monitoring on the selected thermal pin.
package pfcb_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          REG_W           = 8;
    localparam logic [7:0]  OFF_PIN_CFG     = 8'h7D;
    localparam logic [7:0]  OFF_TEST_ONE    = 8'h7E;
    localparam logic [7:0]  OFF_TEST_TWO    = 8'h7F;
    localparam logic [7:0]  OFF_CTRL        = 8'h80;
    localparam logic [7:0]  PIN_CFG_RST     = 8'h00;
    localparam logic [7:0]  TEST_RST        = 8'h00;
    localparam logic [7:0]  CTRL_RST        = 8'h00;
    localparam logic [7:0]  PIN_CFG_MASK    = 8'h0F;
    localparam logic [7:0]  CTRL_MASK       = 8'h03;
    localparam int          BIT_ALERT_SEL   = 0;
    localparam int          BIT_THERMAL_EVENT_LINE_SEL   = 1;
    localparam int          BIT_THR_LO      = 2;
    localparam int          BIT_THR_HI      = 3;
    localparam int          BIT_LOCK        = 0;
    localparam int          BIT_THERMAL_EVENT_LINE_EN    = 1;
    localparam logic [7:0]  THR_MV_CODE0    = 8'h14;
    localparam logic [7:0]  THR_MV_CODE1    = 8'h28;
    localparam logic [7:0]  THR_MV_CODE2    = 8'h50;
    localparam logic [7:0]  THR_MV_CODE3    = 8'h82;
    localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;
endpackage

// file: test/pfcb_host.sv
// Host bus master model for the configuration bank
`timescale 1ns/10ps
module pfcb_host (
    input  wire logic        clk,   // Bus clock
    input  wire logic        wreq,  // Slave stall
    output logic      [7:0]  addr,  // Byte address
    output logic             rd,    // Read request
    output logic             wr,    // Write request
    output logic      [31:0] wdata  // Write data
);
    initial begin
        addr = 8'h00;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0;
    end
    // Holds the request until the edge that samples the stall low
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        do @(posedge clk); while (wreq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
endmodule // pfcb_host

// file: test/test_pin_function_config_bank.sv
// Self-checking bench for the pin function configuration bank
`timescale 1ns/10ps
module test_pin_function_config_bank;
    import pfcb_pkg::*;
    logic        clk, rst, rd, wr, wreq, a_out, a_oe, m25, th_en, m5, th_act;
    logic [7:0]  addr, thr_mv, v;
    logic [31:0] wdata, rdata;
    logic [1:0]  thr_sel;
    logic [31:0] exp_q[$];
    logic [7:0]  thr_tab[4] = '{THR_MV_CODE0, THR_MV_CODE1, THR_MV_CODE2, THR_MV_CODE3};
    int          n_errors = 0;
    int          n_checks = 0;
    pfcb_top pfcb_top_inst(.clk(clk), .rst(rst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(wreq),
        .alert_out(a_out), .alert_oe(a_oe), .meas_2v5_en(m25), .thermal_event_line_en(th_en),
        .meas_5v_en(m5), .thermal_monitor_active(th_act), .tach_threshold_mv(thr_mv),
        .tach_threshold_select(thr_sel));
    pfcb_host pfcb_host_inst(.clk(clk), .wreq(wreq), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Read data is compared at the edge that samples the stall low
    always @(posedge clk) if (rd && wreq === 1'b0) chk("readdata", exp_q.pop_front(), rdata);
    task automatic rdr(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        pfcb_host_inst.xfer(1'b0, a, 32'h0);
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        pfcb_host_inst.xfer(1'b1, a, {24'h0, d});
    endtask
    task automatic pins(input logic [7:0] c);
        repeat (2) @(posedge clk);
        #1;
        chk("alert_oe", 32'(c[0]), 32'(a_oe));
        chk("alert_out", 32'h0, 32'(a_out));
        chk("meas_2v5_en", 32'(!c[0]), 32'(m25));
        chk("thermal_line", 32'(c[1]), 32'(th_en));
        chk("meas_5v_en", 32'(!c[1]), 32'(m5));
        chk("thr_select", 32'(c[3:2]), 32'(thr_sel));
        chk("thr_mv", 32'(thr_tab[c[3:2]]), 32'(thr_mv));
    endtask
    initial begin
        repeat (6000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        rst = 1'b1;
        void'($urandom(32'hE18E85D6));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rdr(OFF_PIN_CFG, 32'h0);
        rdr(OFF_TEST_ONE, 32'h0);
        pins(8'h00);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom());
            v[3:2] = 2'(i);
            wrr(OFF_PIN_CFG, v);
            rdr(OFF_PIN_CFG, 32'(v & PIN_CFG_MASK));
            pins(v);
            chk("monitor_off", 32'h0, 32'(th_act));
        end
        $display("test pin functions done");
        wrr(OFF_TEST_ONE, 8'hFF);
        wrr(OFF_TEST_TWO, 8'hFF);
        rdr(OFF_TEST_TWO, 32'h0);
        rdr(OFF_TEST_ONE, 32'h0);
        rdr(8'h40, UNMAPPED_DATA);
        $display("test read-only done");
        wrr(OFF_PIN_CFG, 8'h02);
        wrr(OFF_CTRL, 8'h03);
        wrr(OFF_PIN_CFG, 8'h0D);
        rdr(OFF_PIN_CFG, 32'h02);
        pins(8'h02);
        chk("monitor", 32'h1, 32'(th_act));
        $display("test lock done");
        tally_and_finish();
    end
endmodule // test_pin_function_config_bank
